// ---- hw/tsm_pkg.sv ----
// Purpose: shared constants and types for the timer slave mode controller
// Assumes: 40 MHz aclk, AXI4-Lite register access
// Notes: every offset, field position and reset value is named here once
`default_nettype none
package tsm_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SLAVE = 8'h04;
  localparam logic [7:0] OFF_CHAN = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_CNT = 8'h10;
  localparam logic [7:0] OFF_RELOAD = 8'h14;
  localparam logic [7:0] OFF_CMP2 = 8'h18;
  // ctrl register fields
  localparam int CTRL_CEN = 0;
  localparam int CTRL_URS = 2;
  localparam int CTRL_CTRL_PRELOAD_ENABLE = 3;
  localparam int CTRL_CTRL_UPDATE_BY_TRIGGER = 4;
  localparam int CTRL_XOR = 7;
  localparam int CTRL_MMS = 8;
  localparam int CTRL_TIE = 12;
  localparam int CTRL_TDE = 13;
  // slave register fields
  localparam int SLV_SMS = 0;
  localparam int SLV_TS = 4;
  localparam int SLV_ETF = 8;
  localparam int SLV_EXT_TRIG_DIVIDER = 12;
  localparam int SLV_ECE = 14;
  localparam int SLV_ETP = 15;
  // channel register fields
  localparam int CH_C1S = 0;
  localparam int CH_C1F = 4;
  localparam int CH_C1P = 8;
  localparam int CH_C1NP = 9;
  localparam int CH_C2S = 12;
  localparam int CH_C2M = 16;
  localparam int CH_C2P = 20;
  // status register fields
  localparam int ST_TIF = 0;
  localparam int ST_UIF = 1;
  localparam int ST_CC1IF = 2;
  localparam int ST_COMIF = 3;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [15:0] RST_RELOAD = 16'hffff;
  // encodings
  localparam logic [2:0] SMS_RESET = 3'h4;
  localparam logic [2:0] SMS_GATED = 3'h5;
  localparam logic [2:0] SMS_TRIG = 3'h6;
  localparam logic [2:0] TS_ED = 3'h4;
  localparam logic [2:0] TS_TI1 = 3'h5;
  localparam logic [2:0] TS_TI2 = 3'h6;
  localparam logic [2:0] TS_ETR = 3'h7;
  localparam logic [2:0] MMS_OC2 = 3'h5;
  localparam logic [2:0] OCM_PWM2 = 3'h7;
  localparam logic [1:0] DIR_OUT = 2'h0;
  localparam logic [1:0] DIR_OWN = 2'h1;
  localparam logic [1:0] DIR_TRC = 2'h3;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam int SYNC_STAGES = 2;
  // timer input pins carried together
  typedef struct packed {
    logic ch1;
    logic ch2;
    logic ch3;
    logic external_trigger_pin;
    logic [3:0] internal_trigger_line;
  } tsm_pins_type;
endpackage : tsm_pkg
`default_nettype wire

// ---- hw/tsm_cond.sv ----
// Purpose: synchroniser plus digital filter for one timer input
// Assumes: input asynchronous to aclk
// Notes: filter code 0 passes the synchronised level straight through
`default_nettype none
module tsm_cond #(
  parameter int STAGES = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  input wire logic [3:0] filt,
  output logic dout
);
  logic [STAGES-1:0] sync_q;
  logic [3:0] run_q;
  logic filt_q;
  logic s;
  assign s = sync_q[STAGES-1];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[STAGES-2:0], din};
    end
  end
  // a level must hold filt+1 samples before it is accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 4'h0;
      filt_q <= 1'b0;
    end else if (s == filt_q) begin
      run_q <= 4'h0;
    end else if (run_q >= filt) begin
      run_q <= 4'h0;
      filt_q <= s;
    end else begin
      run_q <= run_q + 4'h1;
    end
  end
  assign dout = (filt == 4'h0) ? s : filt_q;
endmodule : tsm_cond
`default_nettype wire

// ---- hw/tsm_top.sv ----
// Purpose: slave mode controller and input combiner of a 16-bit timer
// Assumes: AXI4-Lite slave, one clock, ch and external trigger pins resynchronised here, internal trigger lines used as they come
// Notes: compact time base and compare included to drive the features
`default_nettype none
module tsm_top #(
  parameter int CW = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire tsm_pkg::tsm_pins_type pins,
  output logic trigger_output,
  output logic channel_two_out,
  output logic trigger_irq,
  output logic trigger_dma,
  output logic phase_switch_event
);
  logic [31:0] ctrl_q, slave_q, chan_q;
  logic [3:0] stat_q;
  logic [CW-1:0] cnt_q, reload_q, reload_sh_q, cmp2_q, cmp2_sh_q, cap1_q;
  logic [7:0] awaddr_q, araddr_q;
  logic aw_q, w_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic cen_set, cen_clr;
  // --- AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  logic wr_go;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tsm_pkg::AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q > tsm_pkg::OFF_CMP2) ?
          tsm_pkg::AXI_SLVERR : tsm_pkg::AXI_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                        logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction
  logic [31:0] wnew;
  assign wnew = merge(32'h0, wdata_q, wstrb_q);
  // --- AXI4-Lite read, answer one cycle after address taken
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= tsm_pkg::AXI_OKAY;
      araddr_q <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      araddr_q <= s_axi_araddr;
      s_axi_rresp <= tsm_pkg::AXI_OKAY;
      unique case (s_axi_araddr)
        tsm_pkg::OFF_CTRL: s_axi_rdata <= ctrl_q;
        tsm_pkg::OFF_SLAVE: s_axi_rdata <= slave_q;
        tsm_pkg::OFF_CHAN: s_axi_rdata <= chan_q;
        tsm_pkg::OFF_STAT: s_axi_rdata <= {28'h0, stat_q};
        tsm_pkg::OFF_CNT: s_axi_rdata <= {16'h0, cnt_q};
        tsm_pkg::OFF_RELOAD: s_axi_rdata <= {16'h0, reload_q};
        tsm_pkg::OFF_CMP2: s_axi_rdata <= {cap1_q, cmp2_q};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= tsm_pkg::AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // --- decoded configuration fields
  logic [2:0] slave_mode_select, ts, master_output_select, c2m;
  logic [1:0] c1s, c2s, ext_trig_divider;
  logic [3:0] c1f, ext_trig_filter;
  logic ece, ext_trig_polarity, c1p, c1np, c2p, count_enable_bit;
  assign slave_mode_select = slave_q[tsm_pkg::SLV_SMS +: 3];
  assign ts = slave_q[tsm_pkg::SLV_TS +: 3];
  assign ext_trig_filter = slave_q[tsm_pkg::SLV_ETF +: 4];
  assign ext_trig_divider = slave_q[tsm_pkg::SLV_EXT_TRIG_DIVIDER +: 2];
  assign ece = slave_q[tsm_pkg::SLV_ECE];
  assign ext_trig_polarity = slave_q[tsm_pkg::SLV_ETP];
  assign master_output_select = ctrl_q[tsm_pkg::CTRL_MMS +: 3];
  assign count_enable_bit = ctrl_q[tsm_pkg::CTRL_CEN];
  assign c1s = chan_q[tsm_pkg::CH_C1S +: 2];
  assign c1f = chan_q[tsm_pkg::CH_C1F +: 4];
  assign c1p = chan_q[tsm_pkg::CH_C1P];
  assign c1np = chan_q[tsm_pkg::CH_C1NP];
  assign c2s = chan_q[tsm_pkg::CH_C2S +: 2];
  assign c2m = chan_q[tsm_pkg::CH_C2M +: 3];
  assign c2p = chan_q[tsm_pkg::CH_C2P];
  // --- input conditioning: xor combiner then sync and filter
  logic ti1_raw, ti1f, ti2f, etrf;
  assign ti1_raw = ctrl_q[tsm_pkg::CTRL_XOR] ?
    (pins.ch1 ^ pins.ch2 ^ pins.ch3) : pins.ch1;
  logic [2:0] cin, cout;
  logic [3:0] cf [3];
  assign cin = {pins.external_trigger_pin, pins.ch2, ti1_raw};
  assign cf[0] = c1f;
  assign cf[1] = 4'h0;
  assign cf[2] = ext_trig_filter;
  for (genvar g = 0; g < 3; g++) begin : g_cond
    tsm_cond #(.STAGES(tsm_pkg::SYNC_STAGES)) u_cond (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(cin[g]),
      .filt(cf[g]),
      .dout(cout[g])
    );
  end
  assign ti1f = cout[0];
  assign ti2f = cout[1];
  assign etrf = cout[2];
  // polarity: aux bit alone is left as non-inverted
  logic ti1fp, ti2fp, ext_trig_conditioned;
  assign ti1fp = ti1f ^ (c1p & ~c1np);
  assign ti2fp = ti2f ^ c2p;
  assign ext_trig_conditioned = etrf ^ ext_trig_polarity;
  logic ti1_d1_q, ti1fp_d1_q, ti2fp_d1_q, slave_trigger_in_d1_q, etr_d1_q;
  logic [1:0] etdiv_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ti1_d1_q <= 1'b0;
      ti1fp_d1_q <= 1'b0;
      ti2fp_d1_q <= 1'b0;
      etr_d1_q <= 1'b0;
    end else begin
      ti1_d1_q <= ti1f;
      ti1fp_d1_q <= ti1fp;
      ti2fp_d1_q <= ti2fp;
      etr_d1_q <= ext_trig_conditioned;
    end
  end
  logic ti1_ed;
  assign ti1_ed = ti1f ^ ti1_d1_q;
  // --- trigger selection
  logic slave_trigger_in, slave_trigger_in_edge;
  always_comb begin
    slave_trigger_in = 1'b0;
    unique case (ts)
      tsm_pkg::TS_ED: slave_trigger_in = ti1_ed;
      tsm_pkg::TS_TI1: slave_trigger_in = ti1fp;
      tsm_pkg::TS_TI2: slave_trigger_in = ti2fp;
      tsm_pkg::TS_ETR: slave_trigger_in = ext_trig_conditioned;
      default: slave_trigger_in = pins.internal_trigger_line[ts[1:0]];
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slave_trigger_in_d1_q <= 1'b0;
    end else begin
      slave_trigger_in_d1_q <= slave_trigger_in;
    end
  end
  assign slave_trigger_in_edge = (ts == tsm_pkg::TS_ED) ? slave_trigger_in : (slave_trigger_in & ~slave_trigger_in_d1_q);
  // --- external clock mode 2: prescaled edges of the conditioned pin
  logic etr_rise, etr_tick;
  assign etr_rise = ext_trig_conditioned & ~etr_d1_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      etdiv_q <= 2'h0;
    end else if (etr_rise) begin
      etdiv_q <= etdiv_q + 2'h1;
    end
  end
  assign etr_tick = etr_rise &&
    ((ext_trig_divider == 2'h0) || ((etdiv_q & ((2'h1 << ext_trig_divider) - 2'h1)) == 2'h0));
  // --- slave mode actions
  logic is_reset, is_gated, is_trig, gate_on, gate_chg, trig_ev;
  assign is_reset = (slave_mode_select == tsm_pkg::SMS_RESET) && slave_trigger_in_edge;
  assign is_gated = (slave_mode_select == tsm_pkg::SMS_GATED);
  assign is_trig = (slave_mode_select == tsm_pkg::SMS_TRIG) && slave_trigger_in_edge;
  assign gate_on = is_gated && count_enable_bit && slave_trigger_in;
  assign gate_chg = is_gated && count_enable_bit && (slave_trigger_in != slave_trigger_in_d1_q);
  assign trig_ev = is_reset || is_trig || gate_chg;
  assign cen_set = is_trig;
  logic tick, run, upd;
  assign run = is_gated ? gate_on : count_enable_bit;
  assign tick = ece ? etr_tick : 1'b1;
  assign upd = is_reset && !ctrl_q[tsm_pkg::CTRL_URS];
  logic ovf;
  assign ovf = run && tick && (cnt_q >= reload_sh_q);
  // --- counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (is_reset) begin
      cnt_q <= '0;
    end else if (run && tick) begin
      cnt_q <= ovf ? '0 : cnt_q + 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_sh_q <= tsm_pkg::RST_RELOAD;
      cmp2_sh_q <= '0;
    end else if (upd || ovf) begin
      reload_sh_q <= reload_q;
      cmp2_sh_q <= cmp2_q;
    end
  end
  // --- channel one capture on own input or combined trigger
  logic cap_ev;
  always_comb begin
    cap_ev = 1'b0;
    unique case (c1s)
      tsm_pkg::DIR_OWN: cap_ev = ti1fp & ~ti1fp_d1_q;
      tsm_pkg::DIR_TRC: cap_ev = slave_trigger_in_edge;
      default: cap_ev = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap1_q <= '0;
    end else if (cap_ev) begin
      cap1_q <= cnt_q;
    end
  end
  // --- channel two pwm mode 2 reference and master output
  logic channel_two_compare_ref;
  assign channel_two_compare_ref = (c2s == tsm_pkg::DIR_OUT) &&
    (c2m == tsm_pkg::OCM_PWM2) && (cnt_q >= cmp2_sh_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trigger_output <= 1'b0;
      channel_two_out <= 1'b0;
      phase_switch_event <= 1'b0;
    end else begin
      trigger_output <= (master_output_select == tsm_pkg::MMS_OC2) ? channel_two_compare_ref : 1'b0;
      channel_two_out <= channel_two_compare_ref;
      phase_switch_event <= ctrl_q[tsm_pkg::CTRL_CTRL_PRELOAD_ENABLE] &&
        ctrl_q[tsm_pkg::CTRL_CTRL_UPDATE_BY_TRIGGER] && slave_trigger_in_edge;
    end
  end
  // --- registers and sticky flags
  assign cen_clr = 1'b0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= tsm_pkg::RST_ZERO;
      slave_q <= tsm_pkg::RST_ZERO;
      chan_q <= tsm_pkg::RST_ZERO;
      reload_q <= tsm_pkg::RST_RELOAD;
      cmp2_q <= '0;
    end else begin
      if (wr_go) begin
        unique case (awaddr_q)
          tsm_pkg::OFF_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
          tsm_pkg::OFF_SLAVE: slave_q <= merge(slave_q, wdata_q, wstrb_q);
          tsm_pkg::OFF_CHAN: chan_q <= merge(chan_q, wdata_q, wstrb_q);
          tsm_pkg::OFF_RELOAD: reload_q <= CW'(merge({16'h0, reload_q},
                                 wdata_q, wstrb_q));
          tsm_pkg::OFF_CMP2: cmp2_q <= CW'(merge({16'h0, cmp2_q},
                               wdata_q, wstrb_q));
          default: ;
        endcase
      end
      // hardware start in trigger mode wins over a same-cycle write
      if (cen_set) begin
        ctrl_q[tsm_pkg::CTRL_CEN] <= 1'b1;
      end
    end
  end
  // status: write one to clear, hardware set wins
  logic [3:0] st_set, st_clr;
  assign st_set = {phase_switch_event, cap_ev, upd || ovf, trig_ev};
  assign st_clr = (wr_go && awaddr_q == tsm_pkg::OFF_STAT) ?
    wnew[3:0] : 4'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 4'h0;
    end else begin
      stat_q <= (stat_q & ~st_clr) | st_set;
    end
  end
  assign trigger_irq = stat_q[tsm_pkg::ST_TIF] &
    ctrl_q[tsm_pkg::CTRL_TIE];
  assign trigger_dma = stat_q[tsm_pkg::ST_TIF] &
    ctrl_q[tsm_pkg::CTRL_TDE];
endmodule : tsm_top
`default_nettype wire

// ---- tb/tsm_far_model.sv ----
// Purpose: far-side model of hall sensor lines and an external clock
// Assumes: pins are plain levels with no pull or release involved
// Notes: internal trigger lines driven as plain levels by set_itr, no peer timer is modelled
`default_nettype none
module tsm_far_model (
  input wire logic aclk,
  output wire tsm_pkg::tsm_pins_type pins
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] hall_q = 3'h0;
  logic etr_q = 1'b0;
  logic [3:0] itr_q = 4'h0;
  assign pins = '{ch1: hall_q[0], ch2: hall_q[1], ch3: hall_q[2],
                  external_trigger_pin: etr_q, internal_trigger_line: itr_q};
  task automatic clear();
    hall_q <= 3'h0;
    etr_q <= 1'b0;
    itr_q <= 4'h0;
  endtask
  // a peer timer's trigger lines, already in the aclk domain
  task automatic set_itr(input logic [3:0] v);
    @(posedge aclk);
    itr_q <= v;
  endtask
  task automatic toggle(input int i);
    @(posedge aclk);
    hall_q[i] <= ~hall_q[i];
  endtask
  // three clocks wide so the synchroniser never misses a pulse
  task automatic etr_burst(input int n);
    repeat (n) begin
      @(posedge aclk);
      etr_q <= 1'b1;
      repeat (3) @(posedge aclk);
      etr_q <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask
endmodule // tsm_far_model
`default_nettype wire

// ---- tb/tsm_top_assertions.sv ----
// Purpose: port-level checks on the timer slave mode controller
// Assumes: one aclk domain, synchronous active-low aresetn
// Notes: pin-to-event lag bound is loose since sync depth may vary
`default_nettype none
module tsm_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire tsm_pkg::tsm_pins_type pins,
  input wire logic trigger_irq,
  input wire logic trigger_dma,
  input wire logic phase_switch_event
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  tsm_pkg::tsm_pins_type pins_q;
  logic [3:0] since_q;
  // saturating age of the last pin change
  always_ff @(posedge aclk) begin
    pins_q <= pins;
    if (!aresetn) since_q <= 4'hf;
    else if (pins != pins_q) since_q <= 4'h0;
    else if (since_q != 4'hf) since_q <= since_q + 4'h1;
  end
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  write_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response missing");
  write_busy_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  read_once_a: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("read answered twice");
  switch_pulse_a: assert property (
    phase_switch_event |=> !phase_switch_event) else $error("long pulse");
  switch_lag_a: assert property (
    phase_switch_event |-> since_q inside {[4'h1:4'ha]})
    else $error("phase switch not tied to a pin edge");
  flag_hold_a: assert property ($fell(trigger_irq) |->
    $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
    else $error("trigger irq dropped without a write");
  dma_hold_a: assert property ($fell(trigger_dma) |->
    $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
    else $error("trigger dma dropped without a write");
endmodule // tsm_checker
bind tsm_top tsm_checker chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .pins, .trigger_irq, .trigger_dma, .phase_switch_event);
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the timer slave mode controller
// Assumes: 40 MHz aclk, inline AXI4-Lite master
// Notes: design reset before each scenario so counts start at zero
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdat, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [3:0] strb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic tout, c2out, tirq, tdma, psw;
  wire tsm_pkg::tsm_pins_type pins;
  int mismatches = 0;
  int num_checks = 0;
  always #12.5 aclk = ~aclk;
  tsm_far_model far (.aclk(aclk), .pins(pins));
  tsm_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pins(pins), .trigger_output(tout),
    .channel_two_out(c2out), .trigger_irq(tirq), .trigger_dma(tdma),
    .phase_switch_event(psw));
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic timed_out();
    mismatches++;
    $display("wrong value wait expected answer seen none");
    conclude();
  endtask
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ready is combinational, so it is read mid-cycle to avoid races
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ra, rw, got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(negedge aclk);
      ra = awready;
      rw = wready;
      got = bvalid;
      rsp = bresp;
      @(posedge aclk);
      if (ra) awvalid <= 1'b0;
      if (rw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!got) timed_out();
  endtask
  task automatic rd(input logic [7:0] a);
    logic ra, got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(negedge aclk);
      ra = arready;
      got = rvalid;
      rdat = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ra) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!got) timed_out();
  endtask
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    far.clear();
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic wait_c2(input logic v);
    logic s;
    s = ~v;
    for (int n = 0; n < 300 && s !== v; n++) begin
      @(negedge aclk);
      s = c2out;
    end
    if (s !== v) timed_out();
  endtask
  task automatic reset_values();
    rd(tsm_pkg::OFF_CTRL);
    check("ctrl reset", 32'h0, rdat);
    rd(tsm_pkg::OFF_RELOAD);
    check("reload reset", 32'h0000_ffff, rdat);
    // only the low byte lane is written, the upper byte keeps its value
    strb = 4'h1;
    wr(tsm_pkg::OFF_RELOAD, 32'h0000_1234);
    strb = 4'hf;
    rd(tsm_pkg::OFF_RELOAD);
    check("reload byte lane", 32'h0000_ff34, rdat);
    rd(8'h40);
    check("unmapped resp", {30'h0, tsm_pkg::AXI_SLVERR}, {30'h0, rsp});
    check("unmapped data", 32'h0, rdat);
  endtask
  task automatic hall_scenario();
    do_reset();
    wr(tsm_pkg::OFF_CHAN, 32'h0000_0003);
    wr(tsm_pkg::OFF_SLAVE, 32'h0000_0044);
    wr(tsm_pkg::OFF_CTRL, 32'h0000_3081);
    for (int i = 0; i < 3; i++) begin
      repeat (40) @(posedge aclk);
      far.toggle(i);
      repeat (8) @(posedge aclk);
      rd(tsm_pkg::OFF_CNT);
      check("cnt after hall edge", 32'h1, {31'h0, rdat < 32'd20});
    end
    repeat (30) @(posedge aclk);
    rd(tsm_pkg::OFF_CNT);
    check("cnt resumes", 32'h1, {31'h0, rdat > 32'd30});
    rd(tsm_pkg::OFF_STAT);
    check("status after hall", 32'h7, rdat & 32'hf);
    rd(tsm_pkg::OFF_CMP2);
    check("capture taken", 32'h1, {31'h0, rdat[31:16] > 16'd30});
    check("irq and dma", 32'h3, {30'h0, tirq, tdma});
    wr(tsm_pkg::OFF_STAT, 32'h0000_0001);
    check("flag cleared", 32'h0, {31'h0, tirq});
  endtask
  task automatic gated_scenario();
    logic [31:0] c;
    do_reset();
    wr(tsm_pkg::OFF_CHAN, 32'h0000_0101);
    wr(tsm_pkg::OFF_SLAVE, 32'h0000_0055);
    repeat (20) @(posedge aclk);
    rd(tsm_pkg::OFF_CNT);
    check("gated no enable", 32'h0, rdat);
    wr(tsm_pkg::OFF_CTRL, 32'h0000_0001);
    wr(tsm_pkg::OFF_STAT, 32'h0000_0001);
    repeat (20) @(posedge aclk);
    far.toggle(0);
    repeat (8) @(posedge aclk);
    rd(tsm_pkg::OFF_CNT);
    c = rdat;
    check("gated counted", 32'h1, {31'h0, c > 32'd15});
    repeat (20) @(posedge aclk);
    rd(tsm_pkg::OFF_CNT);
    check("gated halted", c, rdat);
    rd(tsm_pkg::OFF_STAT);
    check("flag on stop", 32'h1, rdat & 32'h1);
    wr(tsm_pkg::OFF_STAT, 32'h0000_0001);
    far.toggle(0);
    repeat (8) @(posedge aclk);
    rd(tsm_pkg::OFF_STAT);
    check("flag on start", 32'h1, rdat & 32'h1);
  endtask
  task automatic trigger_scenario();
    logic [31:0] c;
    do_reset();
    wr(tsm_pkg::OFF_CHAN, 32'h0000_1000);
    wr(tsm_pkg::OFF_SLAVE, 32'h0000_0066);
    repeat (10) @(posedge aclk);
    rd(tsm_pkg::OFF_CNT);
    check("before trigger", 32'h0, rdat);
    far.toggle(1);
    repeat (10) @(posedge aclk);
    rd(tsm_pkg::OFF_CNT);
    c = rdat;
    repeat (10) @(posedge aclk);
    rd(tsm_pkg::OFF_CNT);
    check("started on input two", 32'h1, {31'h0, rdat > c});
    rd(tsm_pkg::OFF_STAT);
    check("trigger flag", 32'h1, rdat & 32'h1);
  endtask
  task automatic ext_clock_scenario();
    do_reset();
    wr(tsm_pkg::OFF_CHAN, 32'h0000_0001);
    wr(tsm_pkg::OFF_SLAVE, 32'h0000_4056);
    far.etr_burst(2);
    rd(tsm_pkg::OFF_CNT);
    check("ext before trigger", 32'h0, rdat);
    far.toggle(0);
    repeat (10) @(posedge aclk);
    far.etr_burst(5);
    repeat (6) @(posedge aclk);
    rd(tsm_pkg::OFF_CNT);
    check("ext edges counted", 32'h5, rdat);
    rd(tsm_pkg::OFF_STAT);
    check("ext trigger flag", 32'h1, rdat & 32'h1);
  endtask
  task automatic itr_scenario();
    do_reset();
    wr(tsm_pkg::OFF_SLAVE, 32'h0000_0016);
    rd(tsm_pkg::OFF_CNT);
    check("itr before trigger", 32'h0, rdat);
    far.set_itr(4'h2);
    repeat (10) @(posedge aclk);
    rd(tsm_pkg::OFF_CNT);
    check("itr started", 32'h1, {31'h0, rdat > 32'd5});
    rd(tsm_pkg::OFF_STAT);
    check("itr trigger flag", 32'h1, rdat & 32'h1);
  endtask
  task automatic master_out_scenario();
    int p;
    do_reset();
    wr(tsm_pkg::OFF_RELOAD, 32'h0000_0040);
    wr(tsm_pkg::OFF_CMP2, 32'h0000_0010);
    wr(tsm_pkg::OFF_CHAN, 32'h0007_0001);
    wr(tsm_pkg::OFF_SLAVE, 32'h0000_0054);
    wr(tsm_pkg::OFF_CTRL, 32'h0000_0519);
    // the first trigger also loads the reload and compare shadows
    p = 0;
    far.toggle(0);
    repeat (16) begin
      @(negedge aclk);
      if (psw === 1'b1) p++;
    end
    check("phase switch pulses", 32'h1, p);
    wait_c2(1'b1);
    rd(tsm_pkg::OFF_CNT);
    check("pwm2 after delay", 32'h1, {31'h0, rdat >= 32'h10});
    @(negedge aclk);
    check("master out high", 32'h1, {31'h0, tout});
    wait_c2(1'b0);
    repeat (3) @(negedge aclk);
    check("master out low", 32'h0, {31'h0, tout});
  endtask
  initial begin
    do_reset();
    reset_values();
    hall_scenario();
    gated_scenario();
    trigger_scenario();
    ext_clock_scenario();
    master_out_scenario();
    itr_scenario();
    conclude();
  end
endmodule // tb
`default_nettype wire
